// ### srseq_sequencer.sv
// ============================================================
// Supply reset sequencer top
module srseq_sequencer #(
	parameter int unsigned DELAY_CYCLES = srseq_pkg::POWER_UP_DELAY_CYCLES,
	parameter int unsigned FILTER_CYCLES = srseq_pkg::FILTER_CYCLES
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// Analog detectors and pin
	input wire logic i_supply_rise_ok,
	input wire logic i_brownout_low,
	input wire logic i_brownout_detector_ready,
	input wire logic i_external_clear_pin_n,
	// Configuration bits
	input wire logic i_power_up_delay_enable_n,
	input wire logic [1:0] i_brownout_mode_select,
	input wire logic i_brownout_level_select,
	// Software and core state
	input wire logic i_software_brownout_enable,
	input wire logic i_sleep,
	// Reset and gating outputs
	output logic o_device_reset,
	output logic o_execution_enable,
	output logic o_wake_grant,
	// Brownout detector control and status
	output logic o_brownout_enable,
	output logic o_brownout_level,
	output logic o_brownout_ready_flag
);

	localparam int FILT_W = $clog2(FILTER_CYCLES + 1);
	localparam logic [FILT_W-1:0] FILT_LAST = FILT_W'(FILTER_CYCLES);

	// ============================================================
	// Mode decode
	wire mode_on = (i_brownout_mode_select == srseq_pkg::MODE_ALWAYS_ON);
	wire mode_sleep_off =
		(i_brownout_mode_select == srseq_pkg::MODE_SLEEP_OFF);
	wire mode_sw = (i_brownout_mode_select == srseq_pkg::MODE_SOFTWARE);

	srseq_pkg::srseq_state_e state_q;
	srseq_pkg::srseq_state_e state_d;

	// Detector power per mode; mode 00 leaves it off
	wire asleep = (state_q == srseq_pkg::S_SLEEP);
	wire det_active = mode_on
		| (mode_sleep_off & !asleep)
		| (mode_sw & i_software_brownout_enable);
	// Protection only once the detector reports ready
	wire armed = det_active & i_brownout_detector_ready;

	assign o_brownout_enable = det_active;

	// ============================================================
	// Dip filter
	logic [FILT_W-1:0] filt_q;
	logic [FILT_W-1:0] filt_d;
	logic trip_q;
	logic trip_d;
	wire dip = armed & i_brownout_low;
	wire filt_full = (filt_q == FILT_LAST);

	// Count low cycles; short dips restart the count
	assign filt_d = !dip ? '0 :
		(filt_full ? filt_q : filt_q + FILT_W'(1));
	// Trip after the dip outlasts the filter time
	assign trip_d = dip & (filt_full | trip_q);

	// Filter registers
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			filt_q <= '0;
			trip_q <= srseq_pkg::FLAG_INIT;
		end else begin
			filt_q <= filt_d;
			trip_q <= trip_d;
		end
	end

	// ============================================================
	// Power-up delay timer
	srseq_timer_if tif ();

	// Timer rearmed by supply-rise or dip reset
	assign tif.hold = !i_supply_rise_ok | trip_q;
	assign tif.enable = !i_power_up_delay_enable_n;

	srseq_delay_timer #(
		.DELAY_CYCLES(DELAY_CYCLES)
	) u_delay_timer (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.tif(tif.timer)
	);

	// ============================================================
	// Reset combine
	logic reset_q;
	wire reset_d = !i_supply_rise_ok
		| trip_q
		| tif.running
		| !i_external_clear_pin_n;

	// Reset released on a clock edge only
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			reset_q <= srseq_pkg::RESET_HOLD_INIT;
		end else begin
			reset_q <= reset_d;
		end
	end

	assign o_device_reset = reset_q;

	// ============================================================
	// Start-up and wake-up gating
	// Modes 11 and 10 also need the supply above the threshold
	wire need_level = mode_on | mode_sleep_off;
	wire level_ok = !need_level | !i_brownout_low;
	// Inactive detector starts at once, else wait for ready
	wire startup_ok = !det_active
		| (i_brownout_detector_ready & level_ok);
	// Only mode 10 delays wake-up
	wire wake_ok = !mode_sleep_off
		| i_brownout_detector_ready;

	// Next state
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			srseq_pkg::S_HOLD: begin
				state_d = srseq_pkg::S_START_WAIT;
			end
			srseq_pkg::S_START_WAIT: begin
				if (startup_ok) begin
					state_d = srseq_pkg::S_RUN;
				end
			end
			srseq_pkg::S_RUN: begin
				if (i_sleep) begin
					state_d = srseq_pkg::S_SLEEP;
				end
			end
			srseq_pkg::S_SLEEP: begin
				if (!i_sleep) begin
					state_d = srseq_pkg::S_WAKE_WAIT;
				end
			end
			srseq_pkg::S_WAKE_WAIT: begin
				if (wake_ok) begin
					state_d = srseq_pkg::S_RUN;
				end
			end
			default: begin
				state_d = srseq_pkg::S_HOLD;
			end
		endcase
		if (reset_q) begin
			state_d = srseq_pkg::S_HOLD;
		end
	end

	// State register
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_q <= srseq_pkg::S_HOLD;
		end else begin
			state_q <= state_d;
		end
	end

	assign o_execution_enable = (state_q == srseq_pkg::S_RUN);
	assign o_wake_grant = (state_q == srseq_pkg::S_WAKE_WAIT) & wake_ok;

	// ============================================================
	// Status and level outputs
	logic level_q;
	logic ready_q;

	// Level pick and readable ready flag
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			level_q <= srseq_pkg::FLAG_INIT;
			ready_q <= srseq_pkg::FLAG_INIT;
		end else begin
			level_q <= i_brownout_level_select;
			ready_q <= armed;
		end
	end

	assign o_brownout_level = level_q;
	assign o_brownout_ready_flag = ready_q;

	// ============================================================
	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	property p_supply_hold;
		!i_supply_rise_ok |=> o_device_reset
			##1 (o_device_reset || $past(i_supply_rise_ok));
	endproperty
	a_supply_hold: assert property (p_supply_hold)
		else $error("reset dropped while supply low");

	property p_clear_hold;
		!i_external_clear_pin_n |=> o_device_reset ##1 !o_execution_enable;
	endproperty
	a_clear_hold: assert property (p_clear_hold)
		else $error("clear pin did not hold reset");

	property p_timer_hold;
		tif.running |=> o_device_reset;
	endproperty
	a_timer_hold: assert property (p_timer_hold)
		else $error("reset released while timer runs");

	property p_timer_off;
		i_power_up_delay_enable_n |-> !tif.running;
	endproperty
	a_timer_off: assert property (p_timer_off)
		else $error("timer ran while disabled");

	property p_dip_hold;
		trip_q |=> o_device_reset;
	endproperty
	a_dip_hold: assert property (p_dip_hold)
		else $error("brownout did not hold reset");

	property p_mode_off;
		(i_brownout_mode_select == srseq_pkg::MODE_ALWAYS_OFF)
			|-> !o_brownout_enable;
	endproperty
	a_mode_off: assert property (p_mode_off)
		else $error("detector on in off mode");

	property p_level;
		i_reset_n |=> o_brownout_level == $past(i_brownout_level_select);
	endproperty
	a_level: assert property (p_level)
		else $error("trip level not following selection");

	property p_filter;
		$rose(trip_q) |-> $past(filt_q) == FILT_LAST && $past(dip);
	endproperty
	a_filter: assert property (p_filter)
		else $error("brownout tripped before filter time");

	property p_wake_on;
		(state_q == srseq_pkg::S_WAKE_WAIT) && mode_on && !reset_q
			|-> o_wake_grant ##1 o_execution_enable;
	endproperty
	a_wake_on: assert property (p_wake_on)
		else $error("wake delayed in always-on mode");

	property p_wake_ready;
		o_wake_grant && mode_sleep_off |-> i_brownout_detector_ready;
	endproperty
	a_wake_ready: assert property (p_wake_ready)
		else $error("wake granted before detector ready");

	property p_sw_enable;
		mode_sw |-> o_brownout_enable == i_software_brownout_enable;
	endproperty
	a_sw_enable: assert property (p_sw_enable)
		else $error("software enable not obeyed");

	property p_ready_flag;
		i_reset_n |=> o_brownout_ready_flag == $past(armed);
	endproperty
	a_ready_flag: assert property (p_ready_flag)
		else $error("ready flag wrong");

	property p_start_now;
		(state_q == srseq_pkg::S_START_WAIT) && !det_active && !reset_q
			|=> o_execution_enable;
	endproperty
	a_start_now: assert property (p_start_now)
		else $error("start delayed with detector off");

	property p_forced_ready;
		(state_q == srseq_pkg::S_START_WAIT) && mode_on
			&& i_brownout_detector_ready && !i_brownout_low && !reset_q
			|=> o_execution_enable ##0 o_brownout_ready_flag;
	endproperty
	a_forced_ready: assert property (p_forced_ready)
		else $error("forced-on start saw extra delay");

	property p_release_sync;
		$fell(o_device_reset) |-> $past(!reset_d);
	endproperty
	a_release_sync: assert property (p_release_sync)
		else $error("reset released without all holds clear");

	property p_exec_in_reset;
		o_device_reset |=> !o_execution_enable;
	endproperty
	a_exec_in_reset: assert property (p_exec_in_reset)
		else $error("execution allowed during reset");

	property p_release_now;
		i_reset_n && !reset_d |=> !o_device_reset;
	endproperty
	a_release_now: assert property (p_release_now)
		else $error("reset held with all holds clear");

	property p_short_dip;
		!dip |=> !trip_q;
	endproperty
	a_short_dip: assert property (p_short_dip)
		else $error("trip without a standing dip");

	property p_sleep_off;
		mode_sleep_off && asleep |-> !o_brownout_enable;
	endproperty
	a_sleep_off: assert property (p_sleep_off)
		else $error("detector on in sleep for mode 10");

	property p_start_level;
		(state_q == srseq_pkg::S_START_WAIT) && need_level
			&& i_brownout_low |=> !o_execution_enable;
	endproperty
	a_start_level: assert property (p_start_level)
		else $error("start-up with supply below threshold");

	property p_wake_wait10;
		(state_q == srseq_pkg::S_WAKE_WAIT) && mode_sleep_off
			&& !i_brownout_detector_ready |=> !o_execution_enable;
	endproperty
	a_wake_wait10: assert property (p_wake_wait10)
		else $error("mode 10 wake before detector ready");

	// Main scenarios
	c_wake_grant: cover property ($rose(o_wake_grant));
	c_timer_done: cover property ($fell(tif.running));
	c_dip_trip: cover property ($rose(trip_q));
	c_wake_mode10: cover property (o_wake_grant && mode_sleep_off);
	c_start_run: cover property ($rose(o_execution_enable));

endmodule : srseq_sequencer

// ### srseq_pkg.sv
// ============================================================
// Shared constants for the supply reset sequencer
package srseq_pkg;

	// ============================================================
	// Clock and timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int POWER_UP_DELAY_MS = 64;
	// 64 ms at 40 ns per cycle
	localparam int POWER_UP_DELAY_CYCLES =
		POWER_UP_DELAY_MS * 1_000_000 / CLK_PERIOD_NS;
	// Dip filter time, a least time so it rounds up
	localparam int FILTER_TIME_NS = 1000;
	localparam int FILTER_CYCLES =
		(FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ============================================================
	// Brownout mode field encodings
	localparam logic [1:0] MODE_ALWAYS_ON = 2'h3;
	localparam logic [1:0] MODE_SLEEP_OFF = 2'h2;
	localparam logic [1:0] MODE_SOFTWARE = 2'h1;
	localparam logic [1:0] MODE_ALWAYS_OFF = 2'h0;

	// ============================================================
	// Reset values
	localparam logic RESET_HOLD_INIT = 1'b1;
	localparam logic FLAG_INIT = 1'b0;

	// ============================================================
	// Execution gating states
	typedef enum logic [2:0] {
		S_HOLD,
		S_START_WAIT,
		S_RUN,
		S_SLEEP,
		S_WAKE_WAIT
	} srseq_state_e;

endpackage : srseq_pkg

// ### srseq_timer_if.sv
// ============================================================
// Link between the sequencer and its power-up delay timer
interface srseq_timer_if;
	logic hold;
	logic enable;
	logic running;

	modport timer (input hold, input enable, output running);
	modport ctrl (output hold, output enable, input running);
endinterface : srseq_timer_if

// ### srseq_delay_timer.sv
// ============================================================
// Power-up delay timer: runs once after each supply reset
module srseq_delay_timer #(
	parameter int unsigned DELAY_CYCLES = srseq_pkg::POWER_UP_DELAY_CYCLES
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// Control link
	srseq_timer_if.timer tif
);

	localparam int CNT_W = $clog2(DELAY_CYCLES + 1);
	localparam logic [CNT_W-1:0] LAST = CNT_W'(DELAY_CYCLES - 1);

	logic [CNT_W-1:0] count_q;
	logic [CNT_W-1:0] count_d;
	logic done_q;
	logic done_d;
	wire counting = tif.enable && !done_q;
	wire at_last = (count_q == LAST);

	// Count only once both supply resets are gone
	assign count_d = tif.hold ? '0 :
		(counting ? count_q + CNT_W'(1) : count_q);
	assign done_d = tif.hold ? 1'b0 :
		((counting && at_last) ? 1'b1 : done_q);
	assign tif.running = counting;

	// Counter and done flag
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			count_q <= '0;
			done_q <= 1'b0;
		end else begin
			count_q <= count_d;
			done_q <= done_d;
		end
	end

	// ============================================================
	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	property p_timer_waits;
		tif.hold |=> count_q == '0 && !done_q;
	endproperty
	a_timer_waits: assert property (p_timer_waits)
		else $error("timer advanced during supply reset");

	property p_timer_length;
		$rose(done_q) |-> $past(count_q) == LAST && $past(tif.enable);
	endproperty
	a_timer_length: assert property (p_timer_length)
		else $error("timer finished at wrong count");

endmodule : srseq_delay_timer

// ### srseq_sequencer_tb_top.sv
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
	bad_count++; $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end
// ============================================================
// Self-checking bench for the supply reset sequencer
module srseq_sequencer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned DLY = 20;
	localparam int unsigned FLT = 3;
	logic i_clk, i_reset_n, i_supply_rise_ok, i_brownout_low;
	logic i_brownout_detector_ready, i_external_clear_pin_n;
	logic i_power_up_delay_enable_n, i_brownout_level_select;
	logic i_software_brownout_enable, i_sleep;
	logic [1:0] i_brownout_mode_select;
	logic o_device_reset, o_execution_enable, o_wake_grant;
	logic o_brownout_enable, o_brownout_level, o_brownout_ready_flag;
	int bad_count, tests_run, cycles, n;
	integer seed;
	logic lvl, rdy;

	srseq_sequencer #(.DELAY_CYCLES(DLY), .FILTER_CYCLES(FLT)) u_srseq_sequencer (
		.i_clk(i_clk), .i_reset_n(i_reset_n),
		.i_supply_rise_ok(i_supply_rise_ok), .i_brownout_low(i_brownout_low),
		.i_brownout_detector_ready(i_brownout_detector_ready),
		.i_external_clear_pin_n(i_external_clear_pin_n),
		.i_power_up_delay_enable_n(i_power_up_delay_enable_n),
		.i_brownout_mode_select(i_brownout_mode_select),
		.i_brownout_level_select(i_brownout_level_select),
		.i_software_brownout_enable(i_software_brownout_enable),
		.i_sleep(i_sleep), .o_device_reset(o_device_reset),
		.o_execution_enable(o_execution_enable), .o_wake_grant(o_wake_grant),
		.o_brownout_enable(o_brownout_enable), .o_brownout_level(o_brownout_level),
		.o_brownout_ready_flag(o_brownout_ready_flag));

	// ============================================================
	// Clock and hang guard
	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 6000) begin
			bad_count++;
			print_verdict();
		end
	end

	// Detector power expected for a mode, software bit and sleep state
	function automatic logic exp_en(input logic [1:0] m, input logic sw,
		input logic slp);
		return (m == srseq_pkg::MODE_ALWAYS_ON) ||
			(m == srseq_pkg::MODE_SLEEP_OFF && !slp) ||
			(m == srseq_pkg::MODE_SOFTWARE && sw);
	endfunction : exp_en

	task automatic print_verdict();
		if (bad_count == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : print_verdict

	// Counts sampled cycles with reset still held, bounded
	task automatic count_hold(output int cnt);
		cnt = 0;
		@(negedge i_clk);
		while (o_device_reset === 1'b1 && cnt < 200) begin
			cnt++;
			@(negedge i_clk);
		end
	endtask : count_hold

	// Waits a bounded time for execution to be granted
	task automatic wait_exec(input int lim);
		int k;
		k = 0;
		while (o_execution_enable !== 1'b1 && k < lim) begin
			k++;
			@(negedge i_clk);
		end
	endtask : wait_exec

	task automatic nwait(input int k);
		repeat (k) @(negedge i_clk);
	endtask : nwait

	task automatic pulse_reset();
		@(posedge i_clk);
		i_reset_n <= 1'b0;
		@(posedge i_clk);
		i_reset_n <= 1'b1;
	endtask : pulse_reset

	// ============================================================
	// Main sequence
	initial begin
		seed = 32'h5d3f_cb0d;
		i_reset_n = 1'b0;
		i_supply_rise_ok = 1'b0;
		i_brownout_low = 1'b0;
		i_brownout_detector_ready = 1'b1;
		i_external_clear_pin_n = 1'b1;
		i_power_up_delay_enable_n = 1'b1;
		i_brownout_mode_select = srseq_pkg::MODE_ALWAYS_OFF;
		i_brownout_level_select = 1'b0;
		i_software_brownout_enable = 1'b0;
		i_sleep = 1'b0;
		repeat (3) @(posedge i_clk);
		@(negedge i_clk);
		`CHK(o_device_reset, 1'b1)
		`CHK(o_execution_enable, 1'b0)
		`CHK(o_brownout_ready_flag, 1'b0)
		@(posedge i_clk);
		i_reset_n <= 1'b1;
		// Supply not yet good keeps reset for a random time
		repeat (4 + ($random(seed) & 15)) begin
			@(negedge i_clk);
			`CHK(o_device_reset, 1'b1)
		end
		@(posedge i_clk);
		i_supply_rise_ok <= 1'b1;
		count_hold(n);
		`CHK(n <= 2, 1'b1)
		wait_exec(6);
		`CHK(o_execution_enable, 1'b1)
		// External clear pin extends reset
		@(posedge i_clk);
		i_external_clear_pin_n <= 1'b0;
		nwait(3);
		`CHK(o_device_reset, 1'b1)
		`CHK(o_execution_enable, 1'b0)
		@(posedge i_clk);
		i_external_clear_pin_n <= 1'b1;
		count_hold(n);
		`CHK(n <= 2, 1'b1)
		// Delay timer after supply rise, then after a dip
		@(posedge i_clk);
		i_power_up_delay_enable_n <= 1'b0;
		i_supply_rise_ok <= 1'b0;
		i_brownout_mode_select <= srseq_pkg::MODE_ALWAYS_ON;
		nwait(3);
		@(posedge i_clk);
		i_supply_rise_ok <= 1'b1;
		count_hold(n);
		`CHK(n >= DLY && n <= DLY + 3, 1'b1)
		wait_exec(8);
		@(posedge i_clk);
		i_brownout_low <= 1'b1;
		nwait(DLY + FLT + 8);
		`CHK(o_device_reset, 1'b1)
		@(posedge i_clk);
		i_brownout_low <= 1'b0;
		count_hold(n);
		`CHK(n >= DLY && n <= DLY + 3, 1'b1)
		@(posedge i_clk);
		i_power_up_delay_enable_n <= 1'b1;
		wait_exec(8);
		// Dip filter: short dip ignored, long dip resets
		@(posedge i_clk);
		i_brownout_low <= 1'b1;
		repeat (FLT - 1) @(posedge i_clk);
		i_brownout_low <= 1'b0;
		repeat (6) begin
			@(negedge i_clk);
			`CHK(o_device_reset, 1'b0)
		end
		@(posedge i_clk);
		i_brownout_low <= 1'b1;
		nwait(FLT + 4);
		`CHK(o_device_reset, 1'b1)
		@(posedge i_clk);
		i_brownout_low <= 1'b0;
		count_hold(n);
		`CHK(n <= 2, 1'b1)
		wait_exec(6);
		// Every mode and software bit, random level and readiness
		for (int m = 0; m < 8; m++) begin
			lvl = 1'($random(seed));
			rdy = 1'($random(seed));
			@(posedge i_clk);
			i_brownout_mode_select <= m[1:0];
			i_software_brownout_enable <= m[2];
			i_brownout_level_select <= lvl;
			i_brownout_detector_ready <= rdy;
			nwait(2);
			`CHK(o_brownout_enable, exp_en(m[1:0], m[2], 1'b0))
			`CHK(o_brownout_level, lvl)
			`CHK(o_brownout_ready_flag, exp_en(m[1:0], m[2], 1'b0) & rdy)
		end
		// Dip with the detector off is harmless
		@(posedge i_clk);
		i_brownout_mode_select <= srseq_pkg::MODE_ALWAYS_OFF;
		i_brownout_detector_ready <= 1'b1;
		i_brownout_low <= 1'b1;
		nwait(FLT + 6);
		`CHK(o_device_reset, 1'b0)
		@(posedge i_clk);
		i_brownout_low <= 1'b0;
		// Mode 10: off in sleep, wake waits for ready
		@(posedge i_clk);
		i_brownout_mode_select <= srseq_pkg::MODE_SLEEP_OFF;
		i_sleep <= 1'b1;
		nwait(3);
		`CHK(o_execution_enable, 1'b0)
		`CHK(o_brownout_enable, 1'b0)
		@(posedge i_clk);
		i_brownout_detector_ready <= 1'b0;
		i_sleep <= 1'b0;
		nwait(4);
		`CHK(o_wake_grant, 1'b0)
		`CHK(o_execution_enable, 1'b0)
		@(posedge i_clk);
		i_brownout_detector_ready <= 1'b1;
		wait_exec(4);
		`CHK(o_execution_enable, 1'b1)
		// Mode 11 and software mode: guarded in sleep, no wake delay
		for (int k = 0; k < 2; k++) begin
			@(posedge i_clk);
			i_brownout_mode_select <= k ? srseq_pkg::MODE_SOFTWARE :
				srseq_pkg::MODE_ALWAYS_ON;
			i_software_brownout_enable <= 1'b1;
			i_sleep <= 1'b1;
			nwait(3);
			`CHK(o_brownout_enable, 1'b1)
			@(posedge i_clk);
			i_brownout_detector_ready <= 1'b0;
			i_sleep <= 1'b0;
			nwait(2);
			`CHK(o_wake_grant, 1'b1)
			wait_exec(2);
			`CHK(o_execution_enable, 1'b1)
			@(posedge i_clk);
			i_brownout_detector_ready <= 1'b1;
		end
		// Start-up in mode 11 waits for ready
		@(posedge i_clk);
		i_brownout_mode_select <= srseq_pkg::MODE_ALWAYS_ON;
		i_brownout_detector_ready <= 1'b0;
		pulse_reset();
		nwait(8);
		`CHK(o_execution_enable, 1'b0)
		@(posedge i_clk);
		i_brownout_detector_ready <= 1'b1;
		wait_exec(6);
		`CHK(o_execution_enable, 1'b1)
		`CHK(o_brownout_ready_flag, 1'b1)
		// Software mode disabled starts at once without ready
		@(posedge i_clk);
		i_brownout_mode_select <= srseq_pkg::MODE_SOFTWARE;
		i_software_brownout_enable <= 1'b0;
		i_brownout_detector_ready <= 1'b0;
		pulse_reset();
		wait_exec(6);
		`CHK(o_execution_enable, 1'b1)
		print_verdict();
	end
endmodule : srseq_sequencer_tb_top
